// ### bench/mrie_exec_sva.sv
// assertion checker for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module mrie_exec_sva #(
    parameter int STACK_DEPTH = 8
) (
    // clock and issue
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    // results
    input wire logic instr_ready,
    input wire logic instr_done,
    input wire logic [7:0] work_reg,
    input wire logic [12:0] program_counter,
    input wire logic [7:0] interrupt_control_reg,
    input wire logic [12:0] stack_top_entry,
    input wire mrie_pkg::mrie_fwr_t file_wr
);
    wire logic tk = ce && instr_valid && instr_ready;
    wire logic t_file = tk && (instr & 14'h3F80) == 14'h0080;
    wire logic t_lit = tk && instr[13:10] == 4'hC;
    wire logic t_rlit = tk && instr[13:10] == 4'hD;
    wire logic t_rint = tk && instr == 14'h0009;
    wire logic t_idle = tk && (instr & 14'h3F9F) == 14'h0000;
    wire logic t_ret = t_rlit || t_rint;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    file_move_a: assert property (t_file ##1 ce |-> file_wr.we && instr_done
        && file_wr.addr == $past(instr[6:0]) && file_wr.data == $past(work_reg)) else $error("file write wrong");
    write_cause_a: assert property ($rose(file_wr.we) |-> $past(t_file)) else $error("stray file write");
    lit_load_a: assert property (t_lit ##1 ce |-> instr_done && work_reg == $past(instr[7:0]))
        else $error("literal load wrong");
    one_cycle_a: assert property ((t_file || t_lit || t_idle) ##1 ce |-> instr_ready
        && program_counter == $past(program_counter) + 13'h0001) else $error("short op wrong");
    idle_quiet_a: assert property (t_idle ##1 ce |-> !file_wr.we && $stable(work_reg)
        && $stable(interrupt_control_reg)) else $error("idle op changed state");
    ret_lit_a: assert property (t_rlit ##1 ce |-> work_reg == $past(instr[7:0])
        && program_counter == $past(stack_top_entry)) else $error("literal return wrong");
    ret_int_a: assert property (t_rint ##1 ce |-> interrupt_control_reg[7] && $stable(work_reg)
        && program_counter == $past(stack_top_entry)) else $error("interrupt return wrong");
    two_cycle_a: assert property (t_ret ##1 ce ##1 ce |-> instr_done
        && $past(!instr_done && !instr_ready)) else $error("return length wrong");
    cover property (t_file ##1 ce);
    cover property (t_rlit ##2 tk);
    cover property (t_rint ##1 ce);
endmodule
bind mrie_exec mrie_exec_sva #(.STACK_DEPTH(STACK_DEPTH)) u_sva (.mclk(mclk), .rst(rst), .ce(ce),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done),
    .work_reg(work_reg), .program_counter(program_counter), .interrupt_control_reg(interrupt_control_reg),
    .stack_top_entry(stack_top_entry), .file_wr(file_wr));
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic push_valid = 1'b0;
    logic [12:0] push_addr = 13'h0000;
    logic instr_ready, instr_done, instr_unsupported;
    logic [7:0] work_reg, interrupt_control_reg;
    logic [12:0] program_counter, stack_top_entry;
    mrie_pkg::mrie_fwr_t file_wr;
    logic [45:0] exp_q[$];
    logic [12:0] stk[$];
    logic [7:0] w = 8'h00;
    logic [12:0] pc = 13'h0000;
    logic [7:0] ic = 8'h00;
    int n_mismatch = 0;
    int comparisons = 0;
    always #5 mclk = ~mclk;
    mrie_exec #(.STACK_DEPTH(8)) dut (.mclk(mclk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done),
        .instr_unsupported(instr_unsupported), .push_valid(push_valid), .push_addr(push_addr),
        .work_reg(work_reg), .program_counter(program_counter), .interrupt_control_reg(interrupt_control_reg),
        .stack_top_entry(stack_top_entry), .file_wr(file_wr));
    task automatic chk(input string nm, input logic [45:0] e, input logic [45:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic note(input logic u, input logic [15:0] f);
        exp_q.push_back({w, pc, ic, u, f});
    endtask
    task automatic issue(input int op, input bit frz = 1'b0);
        logic [7:0] k;
        logic [6:0] f;
        logic [13:0] wd;
        k = 8'($urandom);
        f = 7'($urandom);
        wd = {6'h3E, k};
        case (op)
            0: begin
                wd = {7'h01, f};
                pc = pc + 13'h0001;
                note(1'b0, {1'b1, f, w});
            end
            1: begin
                wd = {4'hC, 2'($urandom), k};
                w = k;
                pc = pc + 13'h0001;
                note(1'b0, 16'h0000);
            end
            2: begin
                wd = {7'h00, 2'($urandom), 5'h00};
                pc = pc + 13'h0001;
                note(1'b0, 16'h0000);
            end
            3: begin
                wd = {4'hD, 2'b00, k};
                w = k;
                pc = stk.pop_front();
                note(1'b0, 16'h0000);
            end
            4: begin
                wd = 14'h0009;
                ic[7] = 1'b1;
                pc = stk.pop_front();
                note(1'b0, 16'h0000);
            end
            default: note(1'b1, 16'h0000);
        endcase
        instr = wd;
        instr_valid = 1'b1;
        @(negedge mclk);
        // word held in the flush cycle must be refused
        if (op == 3 || op == 4) begin
            chk("ready", 46'h0, 46'(instr_ready));
            if (frz) begin
                ce = 1'b0;
                repeat (2) @(negedge mclk);
                chk("frozen", 46'h0, 46'({instr_ready, instr_done}));
                ce = 1'b1;
            end
            @(negedge mclk);
        end
    endtask
    task automatic push(input logic [12:0] a);
        instr_valid = 1'b0;
        push_valid = 1'b1;
        push_addr = a;
        stk.push_front(a);
        @(negedge mclk);
        chk("tos", 46'(a), 46'(stack_top_entry));
    endtask
    always @(negedge mclk) begin
        if (!rst && instr_done === 1'b1) begin
            chk("result", exp_q.size() ? exp_q.pop_front() : '1, {work_reg, program_counter,
                interrupt_control_reg, instr_unsupported, file_wr.we, file_wr.we ? file_wr[14:0] : 15'h0000});
        end
    end
    task automatic print_verdict();
        $display("counts: %0d compared, %0d bad", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        int op;
        void'($urandom(92219));
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (40) begin
            op = $urandom_range(3, 0);
            issue(op == 3 ? 5 : op);
        end
        $display("test short ops done");
        repeat (4) push(13'($urandom));
        push_valid = 1'b0;
        for (int i = 0; i < 4; i++) begin
            issue(3 + i % 2, i >= 2);
            issue(0);
        end
        $display("test returns done");
        instr_valid = 1'b0;
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge mclk);
        if (exp_q.size() > 0) n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire

// ### hdl/mrie_exec.sv
// executor for move-to-file, load literal, no-op and the two returns
// Functional notes
// - move_work_to_file copies W to file, one cycle
// - load_literal_to_work loads literal into W, one cycle
// - return_from_interrupt_instr pops stack into PC, two cycles
// - return_from_interrupt_instr sets global_interrupt_enable bit seven
// - return_with_literal_instr loads literal into W
// - return_with_literal_instr pops stack into PC
// - return_with_literal_instr takes two cycles
`timescale 1ns/1ps
`default_nettype none
module mrie_exec #(
    parameter int STACK_DEPTH = mrie_pkg::STACK_DEPTH
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // instruction issue
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    output logic instr_ready,
    output logic instr_done,
    output logic instr_unsupported,
    // return stack push from call or interrupt entry
    input wire logic push_valid,
    input wire logic [12:0] push_addr,
    // architectural state
    output logic [7:0] work_reg,
    output logic [12:0] program_counter,
    output logic [7:0] interrupt_control_reg,
    output logic [12:0] stack_top_entry,
    output mrie_pkg::mrie_fwr_t file_wr
);
    localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

    // parameters the logic cannot serve
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two, at least 2");
    end
    if (mrie_pkg::INSTR_W != 14 || mrie_pkg::DATA_W != 8) begin : g_bad_width
        $error("package data widths do not match the ports");
    end
    if (mrie_pkg::FADDR_W != 7 || mrie_pkg::PC_W != 13) begin : g_bad_addr
        $error("package address widths do not match the ports");
    end
    if (mrie_pkg::FADDR_W + mrie_pkg::DATA_W + 1 != $bits(mrie_pkg::mrie_fwr_t)) begin : g_bad_fwr
        $error("file write record width does not match its fields");
    end

    // architectural and handshake registers
    logic [7:0] w_ff;
    logic [12:0] pc_ff;
    logic [7:0] intctl_ff;
    logic ready_ff;
    logic done_ff;
    logic unsup_ff;
    mrie_pkg::mrie_fwr_t fwr_ff;
    mrie_pkg::mrie_state_t state_ff;
    // return stack
    logic [SP_W-1:0] sp_ff;
    logic [12:0] stack_mem [STACK_DEPTH];
    logic [12:0] tos_ff;

    // decode
    wire logic take = ce && instr_valid && ready_ff;
    wire logic is_move_file = (instr & mrie_pkg::MOVE_FILE_MASK) == mrie_pkg::MOVE_FILE_VAL;
    wire logic is_load_lit = (instr & mrie_pkg::LOAD_LIT_MASK) == mrie_pkg::LOAD_LIT_VAL;
    wire logic is_ret_lit = (instr & mrie_pkg::RET_LIT_MASK) == mrie_pkg::RET_LIT_VAL;
    wire logic is_no_op = (instr & mrie_pkg::NO_OP_MASK) == mrie_pkg::NO_OP_VAL;
    wire logic is_ret_int = (instr & mrie_pkg::RET_INT_MASK) == mrie_pkg::RET_INT_VAL;
    wire mrie_pkg::mrie_op_t op = is_move_file ? mrie_pkg::MRIE_OP_MOVE_FILE :
                                  is_load_lit ? mrie_pkg::MRIE_OP_LOAD_LIT :
                                  is_ret_lit ? mrie_pkg::MRIE_OP_RET_LIT :
                                  is_ret_int ? mrie_pkg::MRIE_OP_RET_INT :
                                  is_no_op ? mrie_pkg::MRIE_OP_NO_OP :
                                  mrie_pkg::MRIE_OP_NONE;
    // operand fields
    wire logic [7:0] lit = instr[mrie_pkg::LIT_LSB +: mrie_pkg::DATA_W];
    wire logic [6:0] faddr = instr[mrie_pkg::FADDR_LSB +: mrie_pkg::FADDR_W];
    // stack pointer moves; a pop beats a push in the same cycle
    wire logic do_pop = take && (is_ret_lit || is_ret_int);
    wire logic do_push = ce && push_valid && !do_pop;
    wire logic [SP_W-1:0] sp_dec = sp_ff - SP_W'(1);
    wire logic [SP_W-1:0] sp_inc = sp_ff + SP_W'(1);
    // entry that becomes the top once the current top is popped
    wire logic [12:0] pop_next = stack_mem[sp_dec - SP_W'(1)];
    wire logic [12:0] pc_inc = pc_ff + mrie_pkg::PC_STEP;

    // next-state values
    logic [7:0] nxt_w;
    logic [12:0] nxt_pc;
    logic [7:0] nxt_intctl;
    logic nxt_ready;
    logic nxt_done;
    logic nxt_unsup;
    mrie_pkg::mrie_fwr_t nxt_fwr;
    mrie_pkg::mrie_state_t nxt_state;

    always_comb begin
        nxt_w = w_ff;
        nxt_pc = pc_ff;
        nxt_intctl = intctl_ff;
        nxt_ready = ready_ff;
        nxt_done = 1'b0;
        nxt_unsup = 1'b0;
        nxt_fwr = '0;
        nxt_state = state_ff;
        case (state_ff)
            mrie_pkg::MRIE_ST_EXEC: begin
                if (take) begin
                    case (op)
                        // one-cycle instructions
                        mrie_pkg::MRIE_OP_MOVE_FILE: begin
                            nxt_fwr.we = 1'b1;
                            nxt_fwr.addr = faddr;
                            nxt_fwr.data = w_ff;
                            nxt_pc = pc_inc;
                            nxt_done = 1'b1;
                        end
                        mrie_pkg::MRIE_OP_LOAD_LIT: begin
                            nxt_w = lit;
                            nxt_pc = pc_inc;
                            nxt_done = 1'b1;
                        end
                        mrie_pkg::MRIE_OP_NO_OP: begin
                            nxt_pc = pc_inc;
                            nxt_done = 1'b1;
                        end
                        // two-cycle returns; the second cycle is the flush
                        mrie_pkg::MRIE_OP_RET_INT: begin
                            nxt_pc = tos_ff;
                            nxt_intctl[mrie_pkg::INTCTL_IRQ_EN_BIT] = 1'b1;
                            nxt_ready = 1'b0;
                            nxt_state = mrie_pkg::MRIE_ST_FLUSH;
                        end
                        mrie_pkg::MRIE_OP_RET_LIT: begin
                            nxt_w = lit;
                            nxt_pc = tos_ff;
                            nxt_ready = 1'b0;
                            nxt_state = mrie_pkg::MRIE_ST_FLUSH;
                        end
                        // outside the subset: flag it, leave state alone
                        default: begin
                            nxt_unsup = 1'b1;
                            nxt_done = 1'b1;
                        end
                    endcase
                end
            end
            mrie_pkg::MRIE_ST_FLUSH: begin
                // second cycle stands in for the discarded prefetch
                if (ce) begin
                    nxt_ready = 1'b1;
                    nxt_done = 1'b1;
                    nxt_state = mrie_pkg::MRIE_ST_EXEC;
                end
            end
            default: begin
                nxt_ready = 1'b1;
                nxt_state = mrie_pkg::MRIE_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            w_ff <= mrie_pkg::W_RST;
            pc_ff <= mrie_pkg::PC_RST;
            intctl_ff <= mrie_pkg::INTCTL_RST;
            ready_ff <= 1'b1;
            done_ff <= 1'b0;
            unsup_ff <= 1'b0;
            fwr_ff <= '0;
            state_ff <= mrie_pkg::MRIE_ST_EXEC;
        end else if (ce) begin
            // everything holds while ce is low
            w_ff <= nxt_w;
            pc_ff <= nxt_pc;
            intctl_ff <= nxt_intctl;
            ready_ff <= nxt_ready;
            done_ff <= nxt_done;
            unsup_ff <= nxt_unsup;
            fwr_ff <= nxt_fwr;
            state_ff <= nxt_state;
        end
    end

    // circular return stack; sp_ff points at the next free slot
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_ff <= '0;
            tos_ff <= mrie_pkg::PC_RST;
        end else if (do_pop) begin
            sp_ff <= sp_dec;
            tos_ff <= pop_next;
        end else if (do_push) begin
            sp_ff <= sp_inc;
            tos_ff <= push_addr;
        end
    end

    // storage is not reset; popping an empty stack reads stale entries
    always_ff @(posedge mclk) begin
        if (do_push) begin
            stack_mem[sp_ff] <= push_addr;
        end
    end

    // outputs straight from flip-flops
    assign work_reg = w_ff;
    assign program_counter = pc_ff;
    assign interrupt_control_reg = intctl_ff;
    assign stack_top_entry = tos_ff;
    assign file_wr = fwr_ff;
    assign instr_ready = ready_ff;
    assign instr_done = done_ff;
    assign instr_unsupported = unsup_ff;
endmodule
`default_nettype wire

// ### hdl/mrie_pkg.sv
// shared constants and types for the move/return instruction executor
package mrie_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;

    // opcode match masks and values, 14-bit instruction word
    localparam logic [13:0] MOVE_FILE_MASK = 14'h3F80;
    localparam logic [13:0] MOVE_FILE_VAL = 14'h0080;
    localparam logic [13:0] LOAD_LIT_MASK = 14'h3C00;
    localparam logic [13:0] LOAD_LIT_VAL = 14'h3000;
    localparam logic [13:0] RET_LIT_MASK = 14'h3C00;
    localparam logic [13:0] RET_LIT_VAL = 14'h3400;
    localparam logic [13:0] NO_OP_MASK = 14'h3F9F;
    localparam logic [13:0] NO_OP_VAL = 14'h0000;
    localparam logic [13:0] RET_INT_MASK = 14'h3FFF;
    localparam logic [13:0] RET_INT_VAL = 14'h0009;

    // operand field positions
    localparam int LIT_LSB = 0;
    localparam int FADDR_LSB = 0;

    // interrupt control register layout
    localparam int INTCTL_IRQ_EN_BIT = 7;

    // reset values and program counter step
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [12:0] PC_STEP = 13'h0001;

    typedef enum logic [2:0] {
        MRIE_OP_NONE,
        MRIE_OP_MOVE_FILE,
        MRIE_OP_LOAD_LIT,
        MRIE_OP_NO_OP,
        MRIE_OP_RET_INT,
        MRIE_OP_RET_LIT
    } mrie_op_t;

    typedef enum logic {
        MRIE_ST_EXEC,
        MRIE_ST_FLUSH
    } mrie_state_t;

    // file register write strobe with its address and data
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } mrie_fwr_t;
endpackage
